// >>> hw/reset_nmi_status_control.sv
// reset cause status, nmi control and regulator control behind an avalon-mm slave
//
// What this block does
// - merge all reset sources into one master reset and flag its cause.
// - deep-sleep flag, bit 10, set when the device left deep sleep.
// - config-mismatch flag, bit 9, set on a configuration mismatch reset.
// - external-pin flag, bit 7, set on a master clear pin reset.
// - software-reset flag, bit 6, set when a software reset executes.
// - watchdog time-out flag, bit 4, set on watchdog time-out.
// - wake-from-sleep flag, bit 3, set when device was in sleep.
// - wake-from-idle flag, bit 2, set when device was in idle.
// - brown-out flag, bit 1, set on brown-out; reads 1 after power-on.
// - power-on flag, bit 0, set on power-on; reads 1 after power-on.
// - unimplemented status bits, bits 31 to 11, 8 and 5, read zero.
// - nmi watchdog flag bit 24; writing 1 raises nmi, starts counter.
// - general nmi flag bit 19: event, write of 1, or key 0x4E.
// - voltage-detect nmi flag bit 18 set by low-voltage detection.
// - clock-fail nmi flag set by clock monitor or a write of 1.
// - sleep watchdog flag bit 16; a write of 1 raises nmi, starts no counter.
// - low 16 bits of nmi register hold the counter reload in clocks.
// - reload zero resets the device one clock after the nmi is raised.
// - counter only for watchdog and clock-fail nmi; clearing cancels reset.
// - regulator bit 0: 1 standby in sleep, 0 stays active; resets 0.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "rst_nmi_params.svh"

module reset_nmi_status_control (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic [7:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [3:0]              byteenable,
  input  wire logic [31:0]             writedata,
  output logic      [31:0]             readdata,
  output logic                         waitrequest,
  input  wire logic                    por_event,
  input  wire logic                    bor_event,
  input  wire logic                    master_clear_pin_n,
  input  wire logic                    config_mismatch_event,
  input  wire logic                    wdt_timeout_event,
  input  wire logic                    wdt_sleep_timeout_event,
  input  wire logic                    deep_sleep_exit_event,
  input  wire logic                    sleep_exit_event,
  input  wire logic                    idle_exit_event,
  input  wire logic                    general_nmi_event,
  input  wire logic                    voltage_detect_event,
  input  wire logic                    clock_fail_event,
  output logic                         master_system_reset,
  output logic                         nmi_request,
  output logic                         regulator_standby_enable,
  output rst_nmi_pkg::cnt_state_t      nmi_counter_state
);
  import rst_nmi_pkg::*;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // byte-lane merge of a write, limited to implemented bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] bm,
                                        input logic [31:0] impl);
    merge = ((old & ~bm) | (wd & bm)) & impl;
  endfunction

  function automatic logic [31:0] at_bit(input int unsigned pos, input logic v);
    at_bit = 32'h0;
    at_bit[pos] = v;
  endfunction

  logic [31:0]              rcs_r;
  logic [31:0]              rcs_nxt;
  logic [31:0]              nmi_r;
  logic [31:0]              nmi_nxt;
  logic [31:0]              pwr_r;
  logic [31:0]              pwr_nxt;
  logic                     wait_r;
  logic [31:0]              rdata_r;
  logic                     master_system_reset_r;
  logic                     nmireq_r;
  cnt_state_t               state_r;
  cnt_state_t               state_nxt;
  logic [`NMI_CNT_W-1:0]    cnt_r;
  logic [`NMI_CNT_W-1:0]    cnt_nxt;
  logic                     key1_ok_r;
  logic                     unlocked_r;
  logic [2:0]               master_clear_pin_sync_r;
  logic                     master_clear_pin_lvl_r;

  // ---------------- bus slave ----------------
  wire        req        = read | write;
  wire        wr_ok      = write & ~wait_r;
  wire [31:0] bm         = be_mask(byteenable);
  wire        sel_rcs    = address == `OFS_RCS;
  wire        sel_unlock = address == `OFS_UNLOCK;
  wire        sel_software_reset_request  = address == `OFS_SOFTWARE_RESET_REQUEST;
  wire        sel_nmi    = address == `OFS_NMI;
  wire        sel_pwr    = address == `OFS_PWR;
  wire        sel_key    = address == `OFS_KEY;
  wire        wr_rcs     = wr_ok & sel_rcs;
  wire        wr_unlock  = wr_ok & sel_unlock & (&byteenable);
  wire        wr_software_reset_request   = wr_ok & sel_software_reset_request;
  wire        wr_nmi     = wr_ok & sel_nmi;
  wire        wr_pwr     = wr_ok & sel_pwr;
  wire        wr_key     = wr_ok & sel_key;

  // unmapped addresses read zero and swallow writes
  wire [31:0] rd_mux =
      sel_rcs    ? (rcs_r & `RCS_MASK) :
      sel_nmi    ? (nmi_r & `NMI_MASK) :
      sel_pwr    ? (pwr_r & `PWR_MASK) :
      sel_unlock ? {31'h0, unlocked_r} :
      32'h0;

  // one wait cycle, then a single answer cycle; back to waiting right after it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else if (ce) begin
      wait_r <= ~(wait_r & req);
      if (wait_r & read)
        rdata_r <= rd_mux;
    end
  end

  assign readdata    = rdata_r;
  assign waitrequest = wait_r;

  // ---------------- master clear pin ----------------
  // the pin is asynchronous: three stages, level accepted when stages 2 and 3 agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      master_clear_pin_sync_r <= 3'h7;
      master_clear_pin_lvl_r  <= 1'b1;
    end else if (ce) begin
      master_clear_pin_sync_r <= {master_clear_pin_sync_r[1:0], master_clear_pin_n};
      if (master_clear_pin_sync_r[1] == master_clear_pin_sync_r[2])
        master_clear_pin_lvl_r <= master_clear_pin_sync_r[2];
    end
  end

  wire master_clear_pin_fire = ~master_clear_pin_sync_r[1] & ~master_clear_pin_sync_r[2] & master_clear_pin_lvl_r;

  // ---------------- unlock and software reset ----------------
  // the request is honoured once per two-key sequence; a later full-word unlock write relocks
  wire sw_fire = wr_software_reset_request & unlocked_r & bm[0] & writedata[0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      key1_ok_r  <= 1'b0;
      unlocked_r <= 1'b0;
    end else if (ce) begin
      if (wr_unlock) begin
        key1_ok_r  <= writedata == `UNLOCK_KEY1;
        unlocked_r <= key1_ok_r & (writedata == `UNLOCK_KEY2);
      end else if (sw_fire) begin
        unlocked_r <= 1'b0;
      end
    end
  end

  // ---------------- reset cause status ----------------
  wire [31:0] rcs_set =
      at_bit(`RCS_DEEP_SLEEP_FLAG, deep_sleep_exit_event) |
      at_bit(`RCS_CMR,   config_mismatch_event) |
      at_bit(`RCS_EXTERNAL_PIN_RESET_FLAG,  master_clear_pin_fire)             |
      at_bit(`RCS_SWR,   sw_fire)               |
      at_bit(`RCS_WATCHDOG_TIMEOUT_FLAG,  wdt_timeout_event)     |
      at_bit(`RCS_SLEEP, sleep_exit_event)      |
      at_bit(`RCS_IDLE,  idle_exit_event)       |
      at_bit(`RCS_BOR,   bor_event)             |
      at_bit(`RCS_POR,   por_event);

  // a hardware set in the same cycle as a clearing write wins
  assign rcs_nxt = (wr_rcs ? merge(rcs_r, writedata, bm, `RCS_MASK) : rcs_r)
                   | rcs_set;

  // ---------------- nmi control ----------------
  wire sw_wdt  = wr_nmi & bm[`NMI_WATCHDOG_TIMEOUT_FLAG] & writedata[`NMI_WATCHDOG_TIMEOUT_FLAG];
  wire sw_cf   = wr_nmi & bm[`NMI_CF] & writedata[`NMI_CF];
  wire key_hit = wr_key & bm[31] & (writedata[31:24] == `NMI_KEY);

  wire [31:0] nmi_set =
      at_bit(`NMI_WATCHDOG_TIMEOUT_FLAG, wdt_timeout_event)           |
      at_bit(`NMI_GENERAL_NMI_FLAG, general_nmi_event | key_hit) |
      at_bit(`NMI_VOLTAGE_DETECT_NMI_FLAG, voltage_detect_event)        |
      at_bit(`NMI_CF,   clock_fail_event)            |
      at_bit(`NMI_SLEEP_WATCHDOG_FLAG, wdt_sleep_timeout_event);

  // writes of 1 to flag bits are stored and so raise the nmi themselves
  assign nmi_nxt = (wr_nmi ? merge(nmi_r, writedata, bm, `NMI_MASK) : nmi_r)
                   | nmi_set;

  assign pwr_nxt = wr_pwr ? merge(pwr_r, writedata, bm, `PWR_MASK) : pwr_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rcs_r <= `RCS_RESET;
      nmi_r <= `NMI_RESET;
      pwr_r <= `PWR_RESET;
    end else if (ce) begin
      rcs_r <= rcs_nxt;
      nmi_r <= nmi_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // ---------------- nmi reset counter ----------------
  // only the watchdog and clock-fail nmis arm it; sleep watchdog does not
  wire cnt_start  = wdt_timeout_event | clock_fail_event | sw_wdt | sw_cf;
  wire nmi_armed  = nmi_r[`NMI_WATCHDOG_TIMEOUT_FLAG] | nmi_r[`NMI_CF];
  wire cnt_expire = (state_r == CNT_RUN) & nmi_armed & (cnt_r == '0);
  wire other_rst  = por_event | bor_event | master_clear_pin_fire | config_mismatch_event
                    | sw_fire;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      CNT_IDLE: begin
        if (cnt_start) begin
          state_nxt = CNT_RUN;
          cnt_nxt   = nmi_nxt[`NMI_CNT_W-1:0];
        end
      end
      CNT_RUN: begin
        if (!nmi_armed)
          state_nxt = CNT_IDLE;
        else if (cnt_r == '0)
          state_nxt = CNT_FIRE;
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      CNT_FIRE: begin
        state_nxt = CNT_IDLE;
      end
      default: begin
        state_nxt = CNT_IDLE;
      end
    endcase
  end

  // reset output is a one-cycle pulse; the flags keep the cause afterwards
  wire master_system_reset_nxt = other_rst | cnt_expire;
  wire nmireq_nxt = |(nmi_nxt & `NMI_FLAGS);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r  <= CNT_IDLE;
      cnt_r    <= '0;
      master_system_reset_r <= 1'b0;
      nmireq_r <= 1'b0;
    end else if (ce) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      master_system_reset_r <= master_system_reset_nxt;
      nmireq_r <= nmireq_nxt;
    end
  end

  assign master_system_reset      = master_system_reset_r;
  assign nmi_request              = nmireq_r;
  assign regulator_standby_enable = pwr_r[`PWR_REGULATOR_STANDBY_ENABLE];
  assign nmi_counter_state        = state_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst || !ce);

  sequence s_load_zero;
    state_r == CNT_IDLE && cnt_start && nmi_nxt[15:0] == 16'h0;
  endsequence

  sequence s_load_two;
    state_r == CNT_IDLE && cnt_start && nmi_nxt[15:0] == 16'h2;
  endsequence

  sequence s_stay_armed;
    nmi_armed [*3];
  endsequence

  a_rcs_after_reset: assert property (
    $past(rst) |-> (rcs_r == 32'h3 && !master_system_reset))
    else $error("status register not 0x3 after reset");

  a_rcs_reserved: assert property (
    (rcs_r & ~32'h000006DF) == 32'h0 && (nmi_r & ~32'h018FFFFF) == 32'h0)
    else $error("unimplemented bit set");

  a_deep_sleep_flag_flag: assert property (
    deep_sleep_exit_event |=> rcs_r[10])
    else $error("deep sleep flag not set");

  a_cmr_flag_rst: assert property (
    config_mismatch_event |=> rcs_r[9] && master_system_reset)
    else $error("mismatch flag or reset missing");

  a_pin_reset: assert property (
    master_clear_pin_fire |=> rcs_r[7] && master_system_reset)
    else $error("pin reset not flagged");

  a_swr_unlocked: assert property (
    sw_fire |=> rcs_r[6] && master_system_reset && !unlocked_r)
    else $error("software reset not executed");

  a_swr_locked: assert property (
    (wr_software_reset_request && !unlocked_r && !other_rst && !cnt_expire) |=> !master_system_reset)
    else $error("locked software reset acted");

  a_watchdog_timeout_flag_both: assert property (
    wdt_timeout_event |=> rcs_r[4] && nmi_r[24] && nmi_request)
    else $error("watchdog flags not set");

  a_sleep_idle: assert property (
    (sleep_exit_event || idle_exit_event)
      |=> (rcs_r[3] || !$past(sleep_exit_event)) && (rcs_r[2] || !$past(idle_exit_event)))
    else $error("sleep or idle flag missing");

  a_key_general_nmi_flag: assert property (
    key_hit |=> nmi_r[19] && nmi_request)
    else $error("nmi key did not set general flag");

  a_zero_reload: assert property (
    s_load_zero ##1 nmi_armed |=> master_system_reset)
    else $error("zero reload did not reset at once");

  a_delay_two: assert property (
    s_load_two ##1 s_stay_armed |-> state_r == CNT_RUN && cnt_r == '0
      && (!master_system_reset || $past(other_rst)) ##1 master_system_reset)
    else $error("reload of two not honoured");

  a_cancel_run: assert property (
    (state_r == CNT_RUN && !nmi_armed && !other_rst) |=> !master_system_reset
      && state_r == CNT_IDLE)
    else $error("cleared nmi still reset");

  a_regulator_standby_enable_out: assert property (
    wr_pwr && byteenable[0] |=> regulator_standby_enable == $past(writedata[0]))
    else $error("regulator bit not written");

  a_cnt_down: assert property (
    (state_r == CNT_RUN && nmi_armed && cnt_r != '0) |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("nmi reset counter did not count down");

  a_software_nmi_trigger_raise: assert property (
    (wr_nmi && byteenable[2] && writedata[`NMI_SOFTWARE_NMI_TRIGGER]) |=> nmi_request && nmi_r[23])
    else $error("software nmi trigger ignored");

  a_voltage_detect_nmi_flag_flag: assert property (
    voltage_detect_event |=> nmi_r[18] && nmi_request)
    else $error("voltage detect nmi not flagged");

  a_sleep_wdt: assert property (
    (wdt_sleep_timeout_event && state_r == CNT_IDLE && !cnt_start)
      |=> nmi_r[16] && nmi_request && state_r == CNT_IDLE)
    else $error("sleep watchdog flag wrong or counter started");

endmodule
`default_nettype wire

// >>> shared/rst_nmi_params.svh
// offsets, field positions, reset values and keys for the reset/nmi block
`ifndef RST_NMI_PARAMS_SVH
`define RST_NMI_PARAMS_SVH

`define OFS_RCS        8'h00
`define OFS_UNLOCK     8'h10
`define OFS_SOFTWARE_RESET_REQUEST      8'h14
`define OFS_NMI        8'h20
`define OFS_PWR        8'h30
`define OFS_KEY        8'h40

`define RCS_POR        0
`define RCS_BOR        1
`define RCS_IDLE       2
`define RCS_SLEEP      3
`define RCS_WATCHDOG_TIMEOUT_FLAG       4
`define RCS_SWR        6
`define RCS_EXTERNAL_PIN_RESET_FLAG       7
`define RCS_CMR        9
`define RCS_DEEP_SLEEP_FLAG      10
`define RCS_MASK       32'h000006DF
`define RCS_RESET      32'h00000003

`define NMI_WATCHDOG_TIMEOUT_FLAG       24
`define NMI_SOFTWARE_NMI_TRIGGER      23
`define NMI_GENERAL_NMI_FLAG       19
`define NMI_VOLTAGE_DETECT_NMI_FLAG       18
`define NMI_CF         17
`define NMI_SLEEP_WATCHDOG_FLAG       16
`define NMI_CNT_W      16
`define NMI_MASK       32'h018FFFFF
`define NMI_FLAGS      32'h018F0000
`define NMI_RESET      32'h00000000

`define PWR_REGULATOR_STANDBY_ENABLE      0
`define PWR_MASK       32'h00000001
`define PWR_RESET      32'h00000000

`define NMI_KEY        8'h4E
`define UNLOCK_KEY1    32'h0000A5A5
`define UNLOCK_KEY2    32'h00005A5A

`endif

// >>> shared/rst_nmi_pkg.sv
// types shared by the reset/nmi block and its bench
`default_nettype none
package rst_nmi_pkg;
  typedef enum logic [1:0] {
    CNT_IDLE = 2'b00,
    CNT_RUN  = 2'b01,
    CNT_FIRE = 2'b11
  } cnt_state_t;
endpackage
`default_nettype wire

// >>> sim/reset_nmi_status_control_test.sv
// self-checking bench for the reset cause, nmi and regulator control block
`timescale 1ns/100ps
`default_nettype none
`include "rst_nmi_params.svh"

module reset_nmi_status_control_test;
  import rst_nmi_pkg::*;
  logic        ref_clk    = 1'b0;
  logic        rst        = 1'b1;
  logic        ce         = 1'b1;
  logic [7:0]  address    = 8'h00;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata  = 32'h0;
  logic [31:0] ev         = 32'h0;
  logic        pin_n      = 1'b1;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        master_system_reset;
  logic        nmi_request;
  logic        regulator_standby_enable;
  cnt_state_t  nmi_counter_state;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          rst_cnt    = 0;
  int          k;
  int          base;
  logic [31:0] seed       = 32'h4166;
  logic [31:0] q;
  logic [31:0] n;
  logic [31:0] f;

  // events share bit positions with the flags they set, so expectations read straight off
  reset_nmi_status_control dut_u (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .por_event(ev[`RCS_POR]), .bor_event(ev[`RCS_BOR]),
    .master_clear_pin_n(pin_n), .config_mismatch_event(ev[`RCS_CMR]),
    .wdt_timeout_event(ev[`NMI_WATCHDOG_TIMEOUT_FLAG]), .wdt_sleep_timeout_event(ev[`NMI_SLEEP_WATCHDOG_FLAG]),
    .deep_sleep_exit_event(ev[`RCS_DEEP_SLEEP_FLAG]), .sleep_exit_event(ev[`RCS_SLEEP]),
    .idle_exit_event(ev[`RCS_IDLE]), .general_nmi_event(ev[`NMI_GENERAL_NMI_FLAG]),
    .voltage_detect_event(ev[`NMI_VOLTAGE_DETECT_NMI_FLAG]), .clock_fail_event(ev[`NMI_CF]),
    .master_system_reset(master_system_reset), .nmi_request(nmi_request),
    .regulator_standby_enable(regulator_standby_enable),
    .nmi_counter_state(nmi_counter_state));

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (master_system_reset === 1'b1) rst_cnt++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] bitv(input int b);
    return 32'h1 << b;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // holds the request until waitrequest is sampled low, releases it at that edge and returns one edge later
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int t;
    t = 0;
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge ref_clk);
      t++;
    end while (waitrequest !== 1'b0 && t < 40);
    if (t >= 40) fail_count++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic fire(input logic [31:0] m);
    ev <= m;
    @(posedge ref_clk);
    ev <= 32'h0;
    @(posedge ref_clk);
  endtask

  task automatic wait_reset(input int lim);
    k = 0;
    while (master_system_reset !== 1'b1 && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
  endtask

  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end

  initial begin
    int sb[6];
    int rs[6];
    int nm[3];
    sb = '{`RCS_POR, `RCS_BOR, `RCS_IDLE, `RCS_SLEEP, `RCS_CMR, `RCS_DEEP_SLEEP_FLAG};
    rs = '{1, 1, 0, 0, 1, 0};
    nm = '{`NMI_GENERAL_NMI_FLAG, `NMI_VOLTAGE_DETECT_NMI_FLAG, `NMI_SLEEP_WATCHDOG_FLAG};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`OFS_RCS); check("status reset", q, `RCS_RESET);
    rd(`OFS_NMI); check("nmi reset", q, `NMI_RESET);
    rd(`OFS_PWR); check("power reset", q, `PWR_RESET);
    check("standby pin reset", {31'h0, regulator_standby_enable}, 32'h0);
    wr(`OFS_RCS, 32'hFFFFFFFF);
    rd(`OFS_RCS); check("status unimpl", q, `RCS_MASK);
    wr(8'h7C, 32'hFFFFFFFF);
    rd(8'h7C); check("unmapped", q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_RCS, 32'h0);
      base = rst_cnt;
      fire(bitv(sb[i]));
      rd(`OFS_RCS);
      if (i == 0) check("por flag", q & bitv(sb[i]), bitv(sb[i]));
      else check("cause flag", q, bitv(sb[i]));
      check("merged reset", rst_cnt - base, rs[i]);
    end
    fire(bitv(`RCS_BOR));
    rd(`OFS_RCS); check("flag persists", q, bitv(`RCS_DEEP_SLEEP_FLAG) | bitv(`RCS_BOR));
    // an event while the clock enable is low must leave no trace
    ce <= 1'b0;
    fire(bitv(`RCS_IDLE));
    ce <= 1'b1;
    rd(`OFS_RCS); check("frozen", q, bitv(`RCS_DEEP_SLEEP_FLAG) | bitv(`RCS_BOR));
    wr(`OFS_RCS, 32'h0);
    base = rst_cnt;
    pin_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    pin_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(`OFS_RCS); check("pin flag", q, bitv(`RCS_EXTERNAL_PIN_RESET_FLAG));
    check("pin reset", rst_cnt - base, 32'h1);
    wr(`OFS_RCS, 32'h0);
    base = rst_cnt;
    wr(`OFS_SOFTWARE_RESET_REQUEST, 32'h1);
    rd(`OFS_RCS); check("locked swreset", q, 32'h0);
    wr(`OFS_UNLOCK, `UNLOCK_KEY1);
    wr(`OFS_UNLOCK, `UNLOCK_KEY2);
    wr(`OFS_SOFTWARE_RESET_REQUEST, 32'h1);
    wr(`OFS_SOFTWARE_RESET_REQUEST, 32'h1);
    rd(`OFS_RCS); check("swreset flag", q, bitv(`RCS_SWR));
    check("swreset once", rst_cnt - base, 32'h1);
    // two event and two software triggers, random reloads with zero and two as corners
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      n = (i == 0) ? 32'h0 : (i == 1) ? 32'h2 : {28'h0, seed[3:0]};
      f = bitv((i % 2 == 0) ? `NMI_WATCHDOG_TIMEOUT_FLAG : `NMI_CF);
      wr(`OFS_NMI, n);
      if (i < 2) fire(f);
      else wr(`OFS_NMI, f | n);
      wait_reset(60);
      check("reset delay", k, n + 32'h1);
      rd(`OFS_NMI); check("nmi flags", q, f | n);
      check("nmi request", {31'h0, nmi_request}, 32'h1);
      if (i == 0) begin
        rd(`OFS_RCS); check("wdt cause", q & bitv(`RCS_WATCHDOG_TIMEOUT_FLAG), bitv(`RCS_WATCHDOG_TIMEOUT_FLAG));
      end
      wr(`OFS_NMI, 32'h0);
    end
    wr(`OFS_NMI, 32'h28);
    fire(bitv(`NMI_WATCHDOG_TIMEOUT_FLAG));
    check("counting", 32'(nmi_counter_state), 32'(CNT_RUN));
    base = rst_cnt;
    wr(`OFS_NMI, 32'h0);
    repeat (60) @(posedge ref_clk);
    check("cancelled reset", rst_cnt - base, 32'h0);
    check("back idle", 32'(nmi_counter_state), 32'(CNT_IDLE));
    for (int i = 0; i < 3; i++) begin
      base = rst_cnt;
      fire(bitv(nm[i]));
      rd(`OFS_NMI); check("nmi source", q, bitv(nm[i]));
      check("no counter", rst_cnt - base, 32'h0);
      wr(`OFS_NMI, 32'h0);
      check("nmi cleared", {31'h0, nmi_request}, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      f = bitv((i == 0) ? `NMI_SOFTWARE_NMI_TRIGGER : nm[i - 1]);
      wr(`OFS_NMI, f);
      check("sw nmi", {31'h0, nmi_request}, 32'h1);
      wr(`OFS_NMI, 32'h0);
      check("zero write", {31'h0, nmi_request}, 32'h0);
    end
    wr(`OFS_KEY, {8'h4F, 24'h0});
    rd(`OFS_NMI); check("wrong key", q, 32'h0);
    wr(`OFS_KEY, {`NMI_KEY, 24'h0});
    rd(`OFS_NMI); check("nmi key", q, bitv(`NMI_GENERAL_NMI_FLAG));
    wr(`OFS_NMI, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(`OFS_PWR, seed);
      rd(`OFS_PWR); check("power reg", q, seed & `PWR_MASK);
      check("standby pin", {31'h0, regulator_standby_enable}, {31'h0, seed[0]});
    end
    wr(`OFS_PWR, 32'h0);
    bus(1'b1, `OFS_PWR, 32'h1, 4'hE);
    rd(`OFS_PWR); check("lane masked", q, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
